// ===== rtl/tri_grad_pkg.sv
// Offsets, layouts and the float conversion for the triangle X gradient setup
package tri_grad_pkg;
    // Parameter slots: start 1/W, red, green, blue, alpha, depth, S/W, T/W
    localparam int         NUM_PARAM      = 8;
    localparam logic [2:0] IDX_W          = 3'h0;
    localparam logic [2:0] IDX_S          = 3'h6;
    localparam logic [2:0] IDX_T          = 3'h7;
    // Register byte offsets; each slot is fixed at idx*8, float at idx*8+4
    localparam logic [7:0] OFF_START_INV_W_FIXED = 8'h00;
    localparam logic [7:0] OFF_START_INV_W_FLOAT = 8'h04;
    localparam logic [7:0] OFF_RED_X_STEP_FIXED  = 8'h08;
    localparam logic [7:0] OFF_RED_X_STEP_FLOAT  = 8'h0C;
    localparam logic [7:0] OFF_GREEN_X_STEP_FIXED = 8'h10;
    localparam logic [7:0] OFF_GREEN_X_STEP_FLOAT = 8'h14;
    localparam logic [7:0] OFF_BLUE_X_STEP_FIXED = 8'h18;
    localparam logic [7:0] OFF_BLUE_X_STEP_FLOAT = 8'h1C;
    localparam logic [7:0] OFF_ALPHA_X_STEP_FIXED = 8'h20;
    localparam logic [7:0] OFF_ALPHA_X_STEP_FLOAT = 8'h24;
    localparam logic [7:0] OFF_DEPTH_X_STEP_FIXED = 8'h28;
    localparam logic [7:0] OFF_DEPTH_X_STEP_FLOAT = 8'h2C;
    localparam logic [7:0] OFF_TEX_S_X_STEP_FIXED = 8'h30;
    localparam logic [7:0] OFF_TEX_S_X_STEP_FLOAT = 8'h34;
    localparam logic [7:0] OFF_TEX_T_X_STEP_FIXED = 8'h38;
    localparam logic [7:0] OFF_TEX_T_X_STEP_FLOAT = 8'h3C;
    localparam logic [7:0] OFF_DRAW_COMMAND_FIXED = 8'h40;
    localparam logic [7:0] OFF_DRAW_COMMAND_FLOAT = 8'h44;
    localparam logic [7:0] OFF_CONTROL           = 8'h48;
    localparam logic [7:0] OFF_STATUS            = 8'h4C;
    localparam int         OFF_LAST_PARAM        = 8'h3C;
    // Control and status fields
    localparam int         CTL_PERSP_BIT  = 0;
    localparam logic       CTL_RESET      = 1'b0;
    localparam int         STS_DIV_BUSY   = 0;
    localparam int         STS_DIV_DONE   = 1;
    localparam int         STS_AREA_NEG   = 2;
    // Fixed formats: fraction bits per slot, colour field width
    localparam int         FRAC_W         = 30;
    localparam int         FRAC_COLOUR    = 12;
    localparam int         FRAC_DEPTH     = 12;
    localparam int         FRAC_TEX       = 18;
    localparam int         COLOUR_MSB     = 23;
    // Float layout and conversion constants
    localparam int         FLT_BIAS       = 8'h7F;
    localparam int         FLT_MANT       = 8'h17;
    localparam logic [31:0] FIX_POS_MAX   = 32'h7FFF_FFFF;
    // Divider: 64 quotient bits, low 32 kept
    localparam int          DIV_STEPS     = 8'h40;
    localparam logic [6:0]  DIV_LAST      = 7'h3F;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Iterated accumulators handed to the pixel pipe
    typedef struct packed {
        logic [31:0] inv_w;
        logic [31:0] red;
        logic [31:0] green;
        logic [31:0] blue;
        logic [31:0] alpha;
        logic [31:0] depth;
        logic [31:0] tex_s;
        logic [31:0] tex_t;
    } acc_t;

    typedef enum logic [2:0] {
        DIV_IDLE = 3'b001,
        DIV_RUN  = 3'b010,
        DIV_DONE = 3'b100
    } div_state_t;

    // Single precision to two's complement fixed with frac fraction bits
    function automatic logic [31:0] flt_to_fix(input logic [31:0] f, input int frac);
        logic [55:0] mant;
        int          sh;
        logic [31:0] mag;
        mant = {32'h0000_0000, 1'b1, f[22:0]};
        sh   = int'(f[30:23]) - FLT_BIAS - FLT_MANT + frac;
        if (f[30:23] == 8'h00) begin
            mag = 32'h0000_0000;
        end else if (sh >= 8 && mant[23:0] != 24'h00_0000 && sh > 7) begin
            mag = FIX_POS_MAX;
        end else if (sh >= 0) begin
            mag = 32'(mant << sh);
        end else if (sh > -24) begin
            mag = 32'(mant >> (-sh));
        end else begin
            mag = 32'h0000_0000;
        end
        return f[31] ? 32'(-mag) : mag;
    endfunction : flt_to_fix
endpackage : tri_grad_pkg

// ===== rtl/tri_grad_setup.sv
// Triangle X gradient setup: register file, converters, iterators, divider
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module tri_grad_setup
    import tri_grad_pkg::*;
(
    input  wire logic        i_clk,          // Core clock, 25 MHz
    input  wire logic        i_rst_b,        // Async reset, active low
    input  wire logic [7:0]  i_awaddr,       // Write address
    input  wire logic        i_awvalid,      // Write address valid
    output logic             o_awready,      // Write address ready
    input  wire logic [31:0] i_wdata,        // Write data
    input  wire logic [3:0]  i_wstrb,        // Write strobes
    input  wire logic        i_wvalid,       // Write data valid
    output logic             o_wready,       // Write data ready
    output logic [1:0]       o_bresp,        // Write response
    output logic             o_bvalid,       // Write response valid
    input  wire logic        i_bready,       // Write response ready
    input  wire logic [7:0]  i_araddr,       // Read address
    input  wire logic        i_arvalid,      // Read address valid
    output logic             o_arready,      // Read address ready
    output logic [31:0]      o_rdata,        // Read data
    output logic [1:0]       o_rresp,        // Read response
    output logic             o_rvalid,       // Read data valid
    input  wire logic        i_rready,       // Read data ready
    input  wire logic        i_step,         // One pixel step pulse
    input  wire logic        i_step_left,    // Step direction, 1 = leftward
    input  wire logic        i_div_req,      // Request perspective divide
    output acc_t             o_acc,          // Iterated accumulators
    output logic             o_draw_start,   // Pulse: triangle command written
    output logic [31:0]      o_area,         // Area value from the command
    output logic [31:0]      o_tex_s_pc,     // Perspective corrected S
    output logic [31:0]      o_tex_t_pc,     // Perspective corrected T
    output logic             o_tex_valid     // Pulse: corrected S,T ready
);

    // Bus state
    logic        aw_have_r, aw_have_nxt;
    logic        w_have_r, w_have_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        do_write;
    logic        do_read;
    // Parameter store, control and command
    logic [31:0] param_r [NUM_PARAM];
    logic [31:0] param_nxt [NUM_PARAM];
    logic        persp_r, persp_nxt;
    logic        draw_r, draw_nxt;
    logic [31:0] area_r, area_nxt;
    acc_t        acc_r, acc_nxt;
    logic [31:0] acc_arr [NUM_PARAM];
    logic [31:0] step_arr [NUM_PARAM];
    // Divider state
    div_state_t  dst_r, dst_nxt;
    logic [6:0]  dcnt_r, dcnt_nxt;
    logic [31:0] div_den_r, div_den_nxt;
    logic        tex_valid_r, tex_valid_nxt;
    logic [63:0] num_r [2];
    logic [63:0] num_nxt [2];
    logic [32:0] rem_r [2];
    logic [32:0] rem_nxt [2];
    logic [63:0] quo_r [2];
    logic [63:0] quo_nxt [2];
    logic [1:0]  neg_r, neg_nxt;
    logic [31:0] pc_r [2];
    logic [31:0] pc_nxt [2];

    // Fraction bits of each slot's fixed form
    function automatic int slot_frac(input logic [2:0] idx);
        if (idx == IDX_W) begin
            return FRAC_W;
        end else if (idx == IDX_S || idx == IDX_T) begin
            return FRAC_TEX;
        end else if (idx == 3'h5) begin
            return FRAC_DEPTH;
        end
        return FRAC_COLOUR;
    endfunction : slot_frac

    // Write channel capture and response
    assign do_write = aw_have_r && w_have_r && !bvalid_r;
    assign do_read  = i_arvalid && !rvalid_r;
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (i_awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = i_awaddr;
        end
        if (i_wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = i_wdata;
            w_strb_nxt = i_wstrb;
        end
        if (do_write) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = (aw_addr_r <= OFF_STATUS && aw_addr_r[1:0] == 2'h0)
                          ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && i_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // Read channel: control and status are readable, parameters read zero
    always_comb begin
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (i_araddr == OFF_CONTROL) begin
                rdata_nxt[CTL_PERSP_BIT] = persp_r;
            end else if (i_araddr == OFF_STATUS) begin
                rdata_nxt[STS_DIV_BUSY] = dst_r == DIV_RUN;
                rdata_nxt[STS_DIV_DONE] = dst_r == DIV_DONE;
                rdata_nxt[STS_AREA_NEG] = area_r[31];
            end else if (i_araddr > OFF_STATUS || i_araddr[1:0] != 2'h0) begin
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && i_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Parameter writes: fixed or float form land in one slot
    always_comb begin
        logic [2:0]  idx;
        logic [31:0] conv;
        idx = aw_addr_r[5:3];
        conv = 32'h0000_0000;
        for (int i = 0; i < NUM_PARAM; i++) begin
            param_nxt[i] = param_r[i];
        end
        persp_nxt = persp_r;
        draw_nxt  = 1'b0;
        area_nxt  = area_r;
        if (aw_addr_r[2]) begin
            conv = flt_to_fix(w_data_r, slot_frac(idx));
        end else if (idx != IDX_W && idx < 3'h5) begin
            conv = {{8{w_data_r[COLOUR_MSB]}}, w_data_r[COLOUR_MSB:0]};
        end else begin
            conv = w_data_r;
        end
        if (do_write && w_strb_r == 4'hF) begin
            if (int'(aw_addr_r) <= OFF_LAST_PARAM && aw_addr_r[1:0] == 2'h0) begin
                param_nxt[idx] = conv;
            end else if (aw_addr_r == OFF_DRAW_COMMAND_FIXED
                         || aw_addr_r == OFF_DRAW_COMMAND_FLOAT) begin
                draw_nxt = 1'b1;
                area_nxt = w_data_r;
            end else if (aw_addr_r == OFF_CONTROL) begin
                persp_nxt = w_data_r[CTL_PERSP_BIT];
            end
        end
    end

    // Iterators: load at command; gradients add on a right step, subtract on a left step; 1/W only loads
    assign acc_arr = '{acc_r.inv_w, acc_r.red, acc_r.green, acc_r.blue,
                       acc_r.alpha, acc_r.depth, acc_r.tex_s, acc_r.tex_t};
    generate
        for (genvar g = 0; g < NUM_PARAM; g++) begin : g_step
            if (g == 0) begin : g_w
                assign step_arr[g] = draw_r ? param_r[g] : acc_arr[g];
            end else begin : g_grad
                assign step_arr[g] = draw_r ? 32'h0000_0000
                                   : (i_step_left ? acc_arr[g] - param_r[g]
                                                  : acc_arr[g] + param_r[g]);
            end
        end
    endgenerate
    always_comb begin
        acc_nxt = acc_r;
        if (draw_r || i_step) begin
            acc_nxt.inv_w = step_arr[0];
            acc_nxt.red   = step_arr[1];
            acc_nxt.green = step_arr[2];
            acc_nxt.blue  = step_arr[3];
            acc_nxt.alpha = step_arr[4];
            acc_nxt.depth = step_arr[5];
            acc_nxt.tex_s = step_arr[6];
            acc_nxt.tex_t = step_arr[7];
        end
    end

    // Perspective divide: restoring, 64 steps, or bypass when disabled
    always_comb begin
        logic [63:0] mag;
        logic [32:0] trial;
        dst_nxt       = dst_r;
        dcnt_nxt      = dcnt_r;
        div_den_nxt   = div_den_r;
        tex_valid_nxt = 1'b0;
        neg_nxt       = neg_r;
        mag           = 64'h0000_0000_0000_0000;
        trial         = 33'h0_0000_0000;
        for (int c = 0; c < 2; c++) begin
            num_nxt[c] = num_r[c];
            rem_nxt[c] = rem_r[c];
            quo_nxt[c] = quo_r[c];
            pc_nxt[c]  = pc_r[c];
        end
        unique case (dst_r)
            DIV_IDLE: begin
                if (i_div_req && !persp_r) begin
                    pc_nxt[0]     = acc_r.tex_s;
                    pc_nxt[1]     = acc_r.tex_t;
                    tex_valid_nxt = 1'b1;
                end else if (i_div_req) begin
                    dst_nxt     = DIV_RUN;
                    dcnt_nxt    = 7'h00;
                    div_den_nxt = acc_r.inv_w[31] ? 32'(-acc_r.inv_w) : acc_r.inv_w;
                    for (int c = 0; c < 2; c++) begin
                        mag = {32'h0000_0000, c == 0 ? acc_r.tex_s : acc_r.tex_t};
                        neg_nxt[c] = mag[31] ^ acc_r.inv_w[31];
                        if (mag[31]) begin
                            mag[31:0] = 32'(-mag[31:0]);
                        end
                        num_nxt[c] = mag << FRAC_W;
                        rem_nxt[c] = 33'h0_0000_0000;
                        quo_nxt[c] = 64'h0000_0000_0000_0000;
                    end
                end
            end
            DIV_RUN: begin
                for (int c = 0; c < 2; c++) begin
                    trial      = {rem_r[c][31:0], num_r[c][63]};
                    num_nxt[c] = {num_r[c][62:0], 1'b0};
                    if (trial >= {1'b0, div_den_r}) begin
                        rem_nxt[c] = trial - {1'b0, div_den_r};
                        quo_nxt[c] = {quo_r[c][62:0], 1'b1};
                    end else begin
                        rem_nxt[c] = trial;
                        quo_nxt[c] = {quo_r[c][62:0], 1'b0};
                    end
                end
                dcnt_nxt = dcnt_r + 7'h01;
                if (dcnt_r == DIV_LAST) begin
                    dst_nxt = DIV_DONE;
                end
            end
            DIV_DONE: begin
                for (int c = 0; c < 2; c++) begin
                    pc_nxt[c] = neg_r[c] ? 32'(-quo_r[c][31:0]) : quo_r[c][31:0];
                end
                tex_valid_nxt = 1'b1;
                dst_nxt       = DIV_IDLE;
            end
            default: begin
                dst_nxt = DIV_IDLE;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_have_r   <= 1'b0;
            w_have_r    <= 1'b0;
            aw_addr_r   <= 8'h00;
            w_data_r    <= 32'h0000_0000;
            w_strb_r    <= 4'h0;
            bvalid_r    <= 1'b0;
            bresp_r     <= RESP_OKAY;
            rvalid_r    <= 1'b0;
            rresp_r     <= RESP_OKAY;
            rdata_r     <= 32'h0000_0000;
            persp_r     <= CTL_RESET;
            draw_r      <= 1'b0;
            area_r      <= 32'h0000_0000;
            acc_r       <= '0;
            dst_r       <= DIV_IDLE;
            dcnt_r      <= 7'h00;
            div_den_r   <= 32'h0000_0000;
            tex_valid_r <= 1'b0;
            neg_r       <= 2'h0;
            for (int i = 0; i < NUM_PARAM; i++) begin
                param_r[i] <= 32'h0000_0000;
            end
            for (int c = 0; c < 2; c++) begin
                num_r[c] <= 64'h0000_0000_0000_0000;
                rem_r[c] <= 33'h0_0000_0000;
                quo_r[c] <= 64'h0000_0000_0000_0000;
                pc_r[c]  <= 32'h0000_0000;
            end
        end else begin
            aw_have_r   <= aw_have_nxt;
            w_have_r    <= w_have_nxt;
            aw_addr_r   <= aw_addr_nxt;
            w_data_r    <= w_data_nxt;
            w_strb_r    <= w_strb_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rresp_r     <= rresp_nxt;
            rdata_r     <= rdata_nxt;
            persp_r     <= persp_nxt;
            draw_r      <= draw_nxt;
            area_r      <= area_nxt;
            acc_r       <= acc_nxt;
            dst_r       <= dst_nxt;
            dcnt_r      <= dcnt_nxt;
            div_den_r   <= div_den_nxt;
            tex_valid_r <= tex_valid_nxt;
            neg_r       <= neg_nxt;
            for (int i = 0; i < NUM_PARAM; i++) begin
                param_r[i] <= param_nxt[i];
            end
            for (int c = 0; c < 2; c++) begin
                num_r[c] <= num_nxt[c];
                rem_r[c] <= rem_nxt[c];
                quo_r[c] <= quo_nxt[c];
                pc_r[c]  <= pc_nxt[c];
            end
        end
    end

    // Outputs straight from flops
    assign o_awready    = !aw_have_r;
    assign o_wready     = !w_have_r;
    assign o_bvalid     = bvalid_r;
    assign o_bresp      = bresp_r;
    assign o_arready    = !rvalid_r;
    assign o_rvalid     = rvalid_r;
    assign o_rresp      = rresp_r;
    assign o_rdata      = rdata_r;
    assign o_acc        = acc_r;
    assign o_draw_start = draw_r;
    assign o_area       = area_r;
    assign o_tex_s_pc   = pc_r[0];
    assign o_tex_t_pc   = pc_r[1];
    assign o_tex_valid  = tex_valid_r;

endmodule : tri_grad_setup

// ===== tb/tri_grad_monitor.sv
// Port-level checks on the triangle X gradient setup
`timescale 1ns/1ns
module tri_grad_monitor
    import tri_grad_pkg::*;
(
    input wire logic i_clk,        // Clock
    input wire logic i_rst_b,      // Reset, active low
    input wire logic i_step,       // Step pulse
    input wire logic i_step_left,  // Step leftward
    input wire acc_t o_acc,        // Accumulators
    input wire logic o_draw_start, // Draw pulse
    input wire logic o_tex_valid   // Divide result pulse
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // Right step followed at once by a left step
    sequence s_rl;
        i_step && !i_step_left && !o_draw_start ##1 i_step && i_step_left && !o_draw_start;
    endsequence
    // Stepping, loading and pulse lengths
    property p_red_rl; s_rl |=> o_acc.red == $past(o_acc.red, 2); endproperty
    a_red_rl: assert property (p_red_rl) else $error("red not restored");
    property p_z_rl; s_rl |=> o_acc.depth == $past(o_acc.depth, 2); endproperty
    a_z_rl: assert property (p_z_rl) else $error("depth not restored");
    property p_st_rl; s_rl |=> {o_acc.tex_s, o_acc.tex_t} ==
        $past({o_acc.tex_s, o_acc.tex_t}, 2); endproperty
    a_st_rl: assert property (p_st_rl) else $error("texture not restored");
    property p_hold; !i_step && !o_draw_start |=> $stable(o_acc); endproperty
    a_hold: assert property (p_hold) else $error("acc moved without step");
    property p_inv_w; !o_draw_start |=> $stable(o_acc.inv_w); endproperty
    a_inv_w: assert property (p_inv_w) else $error("inv_w moved");
    property p_load; o_draw_start |=> o_acc.red == 0 && o_acc.depth == 0 &&
        o_acc.tex_t == 0; endproperty
    a_load: assert property (p_load) else $error("draw did not load");
    property p_draw; o_draw_start |=> !o_draw_start; endproperty
    a_draw: assert property (p_draw) else $error("draw pulse too long");
    property p_tex; o_tex_valid |=> !o_tex_valid; endproperty
    a_tex: assert property (p_tex) else $error("tex pulse too long");
endmodule : tri_grad_monitor

bind tri_grad_setup tri_grad_monitor tri_grad_monitor_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_step(i_step), .i_step_left(i_step_left),
    .o_acc(o_acc), .o_draw_start(o_draw_start), .o_tex_valid(o_tex_valid)
);

// ===== tb/tri_grad_setup_tb.sv
// Self-checking bench for the triangle X gradient setup
`timescale 1ns/1ns
module tri_grad_setup_tb;
    import tri_grad_pkg::*;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, stp = 1'b0, lft = 1'b0, dreq = 1'b0;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, area, tsp, ttp;
    logic [3:0]  ws;
    logic [1:0]  br, rr;
    logic        awv, awr, wv, wr_r, bv, bre, arv, arr, rv, rre, dst, tv;
    acc_t        acc;
    logic [31:0] eg [8];
    // Host loads 1/W and gradients already divided by W
    logic [31:0] gv [8] = '{32'h4000_0000, 32'hAAFF_F000, 32'h0000_0800, 32'h0080_0000,
        32'h007F_FFFF, 32'h0001_8000, 32'h0004_0000, 32'hFFFE_0000};
    logic [31:0] fv [8] = '{32'h3F00_0000, 32'h3F80_0000, 32'hBF00_0000, 32'h4100_0000,
        32'h3D80_0000, 32'h4000_0000, 32'h3F00_0000, 32'hBF80_0000};
    logic [31:0] fe [8] = '{32'h2000_0000, 32'h0000_1000, 32'hFFFF_F800, 32'h0000_8000,
        32'h0000_0100, 32'h0000_2000, 32'h0002_0000, 32'hFFFC_0000};
    int          bad_count = 0, check_count = 0;

    always #20 i_clk = ~i_clk;

    tri_grad_setup tri_grad_setup_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws),
        .i_wvalid(wv), .o_wready(wr_r), .o_bresp(br), .o_bvalid(bv), .i_bready(bre),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr),
        .o_rvalid(rv), .i_rready(rre), .i_step(stp), .i_step_left(lft), .i_div_req(dreq),
        .o_acc(acc), .o_draw_start(dst), .o_area(area), .o_tex_s_pc(tsp),
        .o_tex_t_pc(ttp), .o_tex_valid(tv));
    tri_host_model tri_host_model_inst (.i_clk(i_clk), .o_awaddr(awa), .o_awvalid(awv),
        .i_awready(awr), .o_wdata(wd), .o_wstrb(ws), .o_wvalid(wv), .i_wready(wr_r),
        .i_bresp(br), .i_bvalid(bv), .o_bready(bre), .o_araddr(ara), .o_arvalid(arv),
        .i_arready(arr), .i_rdata(rd), .i_rresp(rr), .i_rvalid(rv), .o_rready(rre));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        tri_host_model_inst.wr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask : wr
    // Step pulses run back to back until quiet drops them
    task automatic stepp(input logic left);
        @(posedge i_clk);
        stp <= 1'b1;
        lft <= left;
    endtask : stepp
    task automatic quiet;
        @(posedge i_clk);
        stp <= 1'b0;
        @(negedge i_clk);
    endtask : quiet
    task automatic draw(input logic [31:0] a);
        wr(OFF_DRAW_COMMAND_FIXED, a);
        quiet();
        chk(area, a);
    endtask : draw
    task automatic cmp_acc(input int m);
        for (int i = 0; i < NUM_PARAM; i++) begin
            chk(acc[255 - 32 * i -: 32], (i == 0) ? eg[0] : 32'(m) * eg[i]);
        end
    endtask : cmp_acc
    task automatic divide;
        int n;
        @(posedge i_clk);
        dreq <= 1'b1;
        @(posedge i_clk);
        dreq <= 1'b0;
        n = 0;
        while (tv !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        chk(32'(n < 100), 32'h0000_0001);
    endtask : divide
    task automatic t_fixed;
        for (int i = 0; i < NUM_PARAM; i++) begin
            wr(8'(i * 8), gv[i]);
            eg[i] = (i > 0 && i < 5) ? {{8{gv[i][23]}}, gv[i][23:0]} : gv[i];
        end
        draw(32'h0000_1234);
        cmp_acc(0);
        stepp(1'b0);
        stepp(1'b0);
        quiet();
        cmp_acc(2);
        stepp(1'b0);
        stepp(1'b1);
        stepp(1'b1);
        quiet();
        cmp_acc(1);
    endtask : t_fixed
    task automatic t_div;
        wr(OFF_START_INV_W_FIXED, 32'h2000_0000);
        wr(OFF_TEX_S_X_STEP_FIXED, 32'h0004_0000);
        wr(OFF_TEX_T_X_STEP_FIXED, 32'hFFFC_0000);
        draw(32'h0000_0100);
        stepp(1'b0);
        quiet();
        divide();
        chk(tsp, 32'h0004_0000);
        chk(ttp, 32'hFFFC_0000);
        wr(OFF_CONTROL, 32'h0000_0001);
        divide();
        chk(tsp, 32'h0008_0000);
        chk(ttp, 32'hFFF8_0000);
    endtask : t_div
    task automatic t_float;
        for (int i = 0; i < NUM_PARAM; i++) begin
            wr(8'(i * 8 + 4), fv[i]);
            eg[i] = fe[i];
        end
        draw(32'h8000_0010);
        stepp(1'b0);
        quiet();
        cmp_acc(1);
        wr(OFF_RED_X_STEP_FIXED, 32'h0000_0100);
        eg[1] = 32'h0000_0100;
        draw(32'h8000_0020);
        stepp(1'b0);
        quiet();
        cmp_acc(1);
    endtask : t_float
    task automatic t_bus;
        logic [31:0] d;
        logic [1:0]  r;
        tri_host_model_inst.rd(OFF_STATUS, d, r);
        chk(32'(d[STS_AREA_NEG]), 32'h0000_0001);
        tri_host_model_inst.rd(OFF_RED_X_STEP_FIXED, d, r);
        chk(d, 32'h0000_0000);
        tri_host_model_inst.rd(8'h50, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        tri_host_model_inst.wr(8'h80, 32'h0000_0000, r);
        chk(32'(r), 32'(RESP_SLVERR));
    endtask : t_bus

    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_fixed();
        t_div();
        t_float();
        t_bus();
        stop_test();
    end
    // Watchdog against a hung handshake
    initial begin
        #400_000;
        bad_count++;
        stop_test();
    end
endmodule : tri_grad_setup_tb

// ===== tb/tri_host_model.sv
// Host AXI4-Lite master loading the setup registers
`timescale 1ns/1ns
module tri_host_model (
    input  wire logic        i_clk,     // Clock
    output logic [7:0]       o_awaddr,  // AW addr
    output logic             o_awvalid, // AW valid
    input  wire logic        i_awready, // AW ready
    output logic [31:0]      o_wdata,   // W data
    output logic [3:0]       o_wstrb,   // W strobes
    output logic             o_wvalid,  // W valid
    input  wire logic        i_wready,  // W ready
    input  wire logic [1:0]  i_bresp,   // B resp
    input  wire logic        i_bvalid,  // B valid
    output logic             o_bready,  // B ready
    output logic [7:0]       o_araddr,  // AR addr
    output logic             o_arvalid, // AR valid
    input  wire logic        i_arready, // AR ready
    input  wire logic [31:0] i_rdata,   // R data
    input  wire logic [1:0]  i_rresp,   // R resp
    input  wire logic        i_rvalid,  // R valid
    output logic             o_rready   // R ready
);
    // Idle bus at time zero, full strobes throughout
    initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    initial {o_awaddr, o_wdata, o_wstrb, o_araddr} = {8'h00, 32'h0000_0000, 4'hF, 8'h00};
    // AW and W offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge i_clk);
        o_awaddr <= a;
        o_awvalid <= 1'b1;
        o_wdata <= d;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge i_clk);
            if (!aw_done && i_awready === 1'b1) begin
                aw_done = 1'b1;
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (!w_done && i_wready === 1'b1) begin
                w_done = 1'b1;
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end
        do @(posedge i_clk); while (i_bvalid !== 1'b1);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask : wr
    // AR until taken, then wait for R
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        do @(posedge i_clk); while (i_arready !== 1'b1);
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
        do @(posedge i_clk); while (i_rvalid !== 1'b1);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask : rd
endmodule : tri_host_model
